// ===== design/adr_pkg.sv
// package: constants and carriers for the analog module diagnostic record
package adr_pkg;

  // access selectors
  localparam logic [7:0] ADR_DS_FULL = 8'h01;
  localparam logic [7:0] ADR_DS_SHORT = 8'h00;
  localparam logic [15:0] ADR_IX_FULL = 16'h2f01;
  localparam logic [15:0] ADR_IX_SHORT = 16'h2f00;
  localparam logic [15:0] ADR_SX_INDEX = 16'h5005;
  localparam logic [7:0] ADR_SX_FIRST = 8'h02;
  localparam logic [7:0] ADR_SX_TICK = 8'h13;
  localparam int ADR_REC_BYTES = 20;
  localparam int ADR_SHORT_BYTES = 4;

  // byte offsets within the record
  localparam logic [4:0] ADR_OFS_SUMMARY = 5'h00;
  localparam logic [4:0] ADR_OFS_CLASS = 5'h01;
  localparam logic [4:0] ADR_OFS_INTERNAL = 5'h03;
  localparam logic [4:0] ADR_OFS_KIND = 5'h04;
  localparam logic [4:0] ADR_OFS_BITS = 5'h05;
  localparam logic [4:0] ADR_OFS_COUNT = 5'h06;
  localparam logic [4:0] ADR_OFS_GROUP = 5'h07;
  localparam logic [4:0] ADR_OFS_CH0 = 5'h08;
  localparam logic [4:0] ADR_OFS_CH1 = 5'h09;
  localparam logic [4:0] ADR_OFS_TICK = 5'h10;

  // constant descriptor values
  localparam logic [3:0] ADR_CLASS_ANALOG = 4'h5;
  localparam int ADR_CLASS_INFO_BIT = 4;
  localparam logic [6:0] ADR_KIND_AIN = 7'h71;
  localparam logic [7:0] ADR_BITS_PER_CH = 8'h08;
  localparam logic [7:0] ADR_CH_COUNT = 8'h02;

  // summary bit positions
  localparam int ADR_SUM_MODFAIL = 0;
  localparam int ADR_SUM_INTERR = 1;
  localparam int ADR_SUM_EXTERR = 2;
  localparam int ADR_SUM_CHANNEL_GROUP_ERRORS = 3;
  localparam int ADR_SUM_AUXMISS = 4;
  localparam int ADR_SUM_PARAM = 7;
  // internal diag and channel fault bit positions
  localparam int ADR_INT_BUFOVF = 3;
  localparam int ADR_INT_COMM = 4;
  localparam int ADR_CHF_CFG = 0;
  localparam int ADR_CHF_UNDER = 6;
  localparam int ADR_CHF_OVER = 7;

  localparam logic [7:0] ADR_BYTE_RST = 8'h00;
  localparam logic [31:0] ADR_TICK_RST = 32'h0000_0000;

  // access path selector
  typedef enum logic [1:0] {
    ADR_PATH_DS = 2'h0,
    ADR_PATH_IX = 2'h1,
    ADR_PATH_SX = 2'h2
  } adr_path_e;

  // module-level fault condition levels
  typedef struct packed {
    logic mod_fail;
    logic int_err;
    logic ext_err;
    logic aux_missing;
    logic param_err;
    logic buf_overflow;
    logic comm_err;
  } adr_mod_fault_s;

  // per channel fault condition levels
  typedef struct packed {
    logic cfg_err;
    logic under;
    logic over;
  } adr_ch_fault_s;

  // read request
  typedef struct packed {
    logic req;
    adr_path_e path;
    logic [15:0] selector;
    logic [7:0] sub;
    logic [4:0] offset;
  } adr_rd_req_s;

  // read answer
  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } adr_rd_rsp_s;

endpackage

// ===== design/adr_diag_record.sv
// analog module diagnostic record: fault capture, tick stamp and read-out
//
// Contract
// - channel fault raises its indicator and record bits; module fault raises record bits only
// - no interrupt; record is polled only
// - record set 01h full, 00h first four
// - index 2f01h full, 2f00h first four
// - index 5005h, one subindex per field from 02h
// - summary bits 0-4 and 7 per error kind
// - internal byte bit 3 overflow, bit 4 comm
// - bits per channel reads 08h
// - channel count reads 02h
// - group error bits 0 and 1
// - channel fault bits 0, 6, 7
// - fault event captures the tick into stamp
// - 32-bit microsecond tick from zero, wraps
module adr_diag_record #(
  parameter int CLK_MHZ = 100
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire adr_pkg::adr_mod_fault_s mod_fault_i,
  input wire adr_pkg::adr_ch_fault_s [1:0] ch_fault_i,
  input wire adr_pkg::adr_rd_req_s rd_req_i,
  output adr_pkg::adr_rd_rsp_s rd_rsp_o,
  output logic [1:0] ch_led_o,
  output logic [31:0] tick_o
);
  import adr_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam int US_DIV = CLK_MHZ;

  typedef struct packed {
    logic [7:0] pre;
    logic [31:0] tick;
    logic [7:0] summary;
    logic [7:0] internal;
    logic [7:0] group;
    logic [7:0] ch0;
    logic [7:0] ch1;
    logic [31:0] stamp;
    logic [1:0] led;
    logic any_prev;
    adr_rd_rsp_s rsp;
  } adr_state_s;

  adr_state_s s_q;
  adr_state_s s_d;

  logic [7:0] sum_n;
  logic [7:0] int_n;
  logic [7:0] grp_n;
  logic [7:0] ch0_n;
  logic [7:0] ch1_n;
  logic any_n;
  logic [4:0] idx;
  logic hit;
  logic [7:0] rbyte;

  // ------------------------------------------------------------
  // record byte lookup
  // ------------------------------------------------------------
  function automatic logic [7:0] rec_byte(input adr_state_s st, input logic [4:0] o);
    logic [7:0] b;
    b = 8'h00;
    case (o)
      ADR_OFS_SUMMARY: b = st.summary;
      ADR_OFS_CLASS: b = {3'h0, 1'b1, ADR_CLASS_ANALOG};
      ADR_OFS_INTERNAL: b = st.internal;
      ADR_OFS_KIND: b = {1'b0, ADR_KIND_AIN};
      ADR_OFS_BITS: b = ADR_BITS_PER_CH;
      ADR_OFS_COUNT: b = ADR_CH_COUNT;
      ADR_OFS_GROUP: b = st.group;
      ADR_OFS_CH0: b = st.ch0;
      ADR_OFS_CH1: b = st.ch1;
      ADR_OFS_TICK: b = st.stamp[7:0];
      ADR_OFS_TICK + 5'h01: b = st.stamp[15:8];
      ADR_OFS_TICK + 5'h02: b = st.stamp[23:16];
      ADR_OFS_TICK + 5'h03: b = st.stamp[31:24];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // channel fault layout, reserved bits zero
    ch0_n = 8'h00;
    ch0_n[ADR_CHF_CFG] = ch_fault_i[0].cfg_err;
    ch0_n[ADR_CHF_UNDER] = ch_fault_i[0].under;
    ch0_n[ADR_CHF_OVER] = ch_fault_i[0].over;
    ch1_n = 8'h00;
    ch1_n[ADR_CHF_CFG] = ch_fault_i[1].cfg_err;
    ch1_n[ADR_CHF_UNDER] = ch_fault_i[1].under;
    ch1_n[ADR_CHF_OVER] = ch_fault_i[1].over;
    grp_n = {6'h00, |ch1_n, |ch0_n};
    sum_n = 8'h00;
    sum_n[ADR_SUM_MODFAIL] = mod_fault_i.mod_fail;
    sum_n[ADR_SUM_INTERR] = mod_fault_i.int_err;
    sum_n[ADR_SUM_EXTERR] = mod_fault_i.ext_err;
    // channel error from any fault bit
    sum_n[ADR_SUM_CHANNEL_GROUP_ERRORS] = |grp_n;
    sum_n[ADR_SUM_AUXMISS] = mod_fault_i.aux_missing;
    sum_n[ADR_SUM_PARAM] = mod_fault_i.param_err;
    int_n = 8'h00;
    int_n[ADR_INT_BUFOVF] = mod_fault_i.buf_overflow;
    int_n[ADR_INT_COMM] = mod_fault_i.comm_err;
    any_n = |{sum_n, int_n};

    if (s_q.pre == 8'(US_DIV - 1)) begin
      s_d.pre = 8'h00;
      s_d.tick = s_q.tick + 32'h1;
    end else begin
      s_d.pre = s_q.pre + 8'h01;
    end

    // record reflects current fault levels, leds follow
    s_d.summary = sum_n;
    s_d.internal = int_n;
    s_d.group = grp_n;
    s_d.ch0 = ch0_n;
    s_d.ch1 = ch1_n;
    s_d.led = grp_n[1:0];
    s_d.any_prev = any_n;
    // stamp on the rise of a diagnostic event
    if (any_n && !s_q.any_prev) begin
      s_d.stamp = s_q.tick;
    end

    hit = 1'b0;
    idx = 5'h00;
    case (rd_req_i.path)
      ADR_PATH_DS: begin
        idx = rd_req_i.offset;
        if (rd_req_i.selector == {8'h00, ADR_DS_FULL}) begin
          hit = 32'(rd_req_i.offset) < ADR_REC_BYTES;
        end else if (rd_req_i.selector == {8'h00, ADR_DS_SHORT}) begin
          hit = 32'(rd_req_i.offset) < ADR_SHORT_BYTES;
        end
      end
      ADR_PATH_IX: begin
        idx = rd_req_i.offset;
        if (rd_req_i.selector == ADR_IX_FULL) begin
          hit = 32'(rd_req_i.offset) < ADR_REC_BYTES;
        end else if (rd_req_i.selector == ADR_IX_SHORT) begin
          hit = 32'(rd_req_i.offset) < ADR_SHORT_BYTES;
        end
      end
      ADR_PATH_SX: begin
        // single-byte fields sit one per subindex; tick field spans offset bytes
        if (rd_req_i.selector == ADR_SX_INDEX) begin
          if (rd_req_i.sub == ADR_SX_TICK) begin
            hit = rd_req_i.offset < 5'h04;
            idx = ADR_OFS_TICK + rd_req_i.offset;
          end else if (rd_req_i.sub >= ADR_SX_FIRST && rd_req_i.sub <= 8'h11) begin
            // reserved subindexes land on the zero bytes 2 and 10 to 15
            hit = rd_req_i.offset == 5'h00;
            idx = 5'(rd_req_i.sub - ADR_SX_FIRST);
          end
        end
      end
      default: hit = 1'b0;
    endcase
    rbyte = hit ? rec_byte(s_q, idx) : 8'h00;
    s_d.rsp.valid = rd_req_i.req;
    s_d.rsp.hit = rd_req_i.req & hit;
    s_d.rsp.data = rd_req_i.req ? rbyte : 8'h00;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // no interrupt output exists; answers only on request
  assign rd_rsp_o = s_q.rsp;
  assign ch_led_o = s_q.led;
  assign tick_o = s_q.tick;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence fault0_seen;
    clk_en_i && ch_fault_i[0].over;
  endsequence

  sequence rd_taken;
    clk_en_i && rd_req_i.req;
  endsequence

  sequence ds_full_rd;
    clk_en_i && rd_req_i.req && rd_req_i.path == ADR_PATH_DS && rd_req_i.selector == 16'h0001;
  endsequence

  sequence ix_full_rd;
    clk_en_i && rd_req_i.req && rd_req_i.path == ADR_PATH_IX && rd_req_i.selector == 16'h2f01;
  endsequence

  sequence sx_field_rd;
    clk_en_i && rd_req_i.req && rd_req_i.path == ADR_PATH_SX && rd_req_i.selector == 16'h5005;
  endsequence

  // first enabled cycle with any fault level while the record is still clean
  sequence diag_rise;
    clk_en_i && (|{mod_fault_i, ch_fault_i}) && !(|{s_q.summary, s_q.internal});
  endsequence

  // ------------------------------------------------------------
  // indicators and answers
  // ------------------------------------------------------------
  chk_led_follows_fault: assert property (fault0_seen |=> ch_led_o[0])
    else $error("channel 0 led not lit after overflow");
  chk_led_clears: assert property (clk_en_i && !(|ch_fault_i[1]) |=> !ch_led_o[1])
    else $error("channel 1 led lit without fault");
  chk_no_answer_idle: assert property (clk_en_i && !rd_req_i.req |=> !rd_rsp_o.valid)
    else $error("answer without request");
  chk_answer_next: assert property (rd_taken |=> rd_rsp_o.valid)
    else $error("request not answered next cycle");
  chk_miss_reads_zero: assert property (rd_rsp_o.valid && !rd_rsp_o.hit
      |-> rd_rsp_o.data == 8'h00)
    else $error("unmapped read returned data");
  // reset wins over the enable, so this one ignores the default disable
  chk_reset_clears: assert property (disable iff (1'b0) srst_i
      |=> rd_rsp_o == '0 && ch_led_o == 2'b00 && tick_o == 32'h0)
    else $error("reset left state behind");

  // ------------------------------------------------------------
  // addressing
  // ------------------------------------------------------------
  // constant bytes are written as literals on purpose, not from the package
  chk_ds_short_limit: assert property (clk_en_i && rd_req_i.req
      && rd_req_i.path == ADR_PATH_DS && rd_req_i.selector == 16'h0000
      && rd_req_i.offset >= 5'h04 |=> !rd_rsp_o.hit)
    else $error("short record set read past four bytes");
  chk_ds_full_hit: assert property (ds_full_rd ##0 rd_req_i.offset < 5'h14
      |=> rd_rsp_o.hit)
    else $error("full record set byte not mapped");
  chk_ix_short_limit: assert property (clk_en_i && rd_req_i.req
      && rd_req_i.path == ADR_PATH_IX && rd_req_i.selector == 16'h2f00
      && rd_req_i.offset >= 5'h04 |=> !rd_rsp_o.hit)
    else $error("short index read past four bytes");
  chk_ix_class_read: assert property (ix_full_rd ##0 rd_req_i.offset == 5'h01
      |=> rd_rsp_o.data == 8'h15)
    else $error("class byte wrong via index");
  chk_ix_count_read: assert property (ix_full_rd ##0 rd_req_i.offset == 5'h06
      |=> rd_rsp_o.data == 8'h02)
    else $error("channel count wrong via index");
  chk_ds_class_read: assert property (ds_full_rd ##0 rd_req_i.offset == 5'h01
      |=> rd_rsp_o.data == 8'h15)
    else $error("class byte wrong via record set");
  chk_ds_kind_read: assert property (ds_full_rd ##0 rd_req_i.offset == 5'h04
      |=> rd_rsp_o.data == 8'h71)
    else $error("channel kind wrong via record set");
  chk_ds_bits_read: assert property (ds_full_rd ##0 rd_req_i.offset == 5'h05
      |=> rd_rsp_o.data == 8'h08)
    else $error("bit count wrong via record set");
  chk_sx_kind_read: assert property (sx_field_rd
      ##0 rd_req_i.sub == 8'h06 && rd_req_i.offset == 5'h00 |=> rd_rsp_o.data == 8'h71)
    else $error("channel kind wrong via subindex");
  chk_sx_bad_index: assert property (clk_en_i && rd_req_i.req
      && rd_req_i.path == ADR_PATH_SX && rd_req_i.selector != 16'h5005
      |=> !rd_rsp_o.hit)
    else $error("foreign index answered");
  chk_sx_reserved_zero: assert property (sx_field_rd
      ##0 rd_req_i.sub >= 8'h0c && rd_req_i.sub <= 8'h11 |=> rd_rsp_o.data == 8'h00)
    else $error("reserved subindex not zero");

  // ------------------------------------------------------------
  // record layouts
  // ------------------------------------------------------------
  // layouts are held against the raw levels one cycle back
  chk_summary_layout: assert property (clk_en_i |=> s_q.summary == $past({
      mod_fault_i.param_err, 2'b00, mod_fault_i.aux_missing, |ch_fault_i,
      mod_fault_i.ext_err, mod_fault_i.int_err, mod_fault_i.mod_fail}))
    else $error("summary byte layout wrong");
  chk_internal_layout: assert property (clk_en_i |=> s_q.internal == $past({
      3'b000, mod_fault_i.comm_err, mod_fault_i.buf_overflow, 3'b000}))
    else $error("internal byte layout wrong");
  chk_group_layout: assert property (clk_en_i |=> s_q.group == $past({
      6'h00, |ch_fault_i[1], |ch_fault_i[0]}))
    else $error("group byte layout wrong");
  chk_ch0_layout: assert property (clk_en_i |=> s_q.ch0 == $past({
      ch_fault_i[0].over, ch_fault_i[0].under, 5'h00, ch_fault_i[0].cfg_err}))
    else $error("channel 0 fault byte layout wrong");
  chk_ch1_layout: assert property (clk_en_i |=> s_q.ch1 == $past({
      ch_fault_i[1].over, ch_fault_i[1].under, 5'h00, ch_fault_i[1].cfg_err}))
    else $error("channel 1 fault byte layout wrong");
  chk_sum_chan_bit: assert property (s_q.ch1 != 8'h00 |-> s_q.summary[3] && s_q.group[1])
    else $error("channel fault not summarised");
  chk_reserved_zero: assert property (s_q.ch0[5:1] == 5'h00 && s_q.group[7:2] == 6'h00)
    else $error("reserved bits set");

  // ------------------------------------------------------------
  // tick and stamp
  // ------------------------------------------------------------
  chk_tick_advance: assert property (clk_en_i && s_q.pre == 8'(US_DIV - 1)
      |=> tick_o == $past(tick_o) + 32'h1)
    else $error("tick did not advance");
  chk_tick_hold: assert property (clk_en_i && s_q.pre != 8'(US_DIV - 1)
      |=> $stable(tick_o))
    else $error("tick moved between microseconds");
  chk_freeze_tick: assert property (!clk_en_i |=> $stable(tick_o) && $stable(rd_rsp_o))
    else $error("state moved while enable low");
  chk_pre_range: assert property (s_q.pre < 8'(US_DIV))
    else $error("prescaler out of range");
  chk_stamp_capture: assert property (diag_rise |=> s_q.stamp == $past(s_q.tick))
    else $error("stamp not captured");
  // a fault that stays up must not restamp; only a fresh event does
  chk_stamp_hold: assert property (clk_en_i && (|{s_q.summary, s_q.internal})
      |=> $stable(s_q.stamp))
    else $error("stamp moved without a new event");
  chk_sx_stamp_read: assert property (sx_field_rd
      ##0 rd_req_i.sub == 8'h13 && rd_req_i.offset == 5'h00 |=> rd_rsp_o.data == $past(s_q.stamp[7:0]))
    else $error("stamp byte wrong via subindex");

endmodule

// ===== testbench/adr_reader.sv
// host reader model: one record read per call
module adr_reader (
  input wire logic clk_i,
  output adr_pkg::adr_rd_req_s req_o,
  input wire adr_pkg::adr_rd_rsp_s rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import adr_pkg::*;
  initial req_o = '0;
  task automatic read(input adr_path_e p, input logic [15:0] sel, input logic [7:0] sb,
                      input logic [4:0] ofs, output adr_rd_rsp_s rsp);
    adr_rd_req_s rel;
    @(negedge clk_i);
    req_o = '{req: 1'b1, path: p, selector: sel, sub: sb, offset: ofs};
    @(negedge clk_i);
    // the answer stands only until the next enabled edge, so take it here
    rsp = rsp_i;
    // released lines do not keep the old address
    rel = ~req_o;
    rel.req = 1'b0;
    req_o = rel;
  endtask
endmodule

// ===== testbench/adr_diag_record_tb.sv
// self-checking bench for the diagnostic record
module adr_diag_record_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adr_pkg::*;
  logic sys_clk_i;
  logic srst_i;
  logic clk_en_i;
  adr_mod_fault_s mod_fault;
  adr_ch_fault_s [1:0] ch_fault;
  adr_rd_req_s rd_req;
  adr_rd_rsp_s rd_rsp;
  logic [1:0] ch_led;
  logic [31:0] tick;
  logic [31:0] held;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int stamp = 0;
  int seed = 66240;

  adr_diag_record #(.CLK_MHZ(100)) dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .clk_en_i(clk_en_i), .mod_fault_i(mod_fault), .ch_fault_i(ch_fault),
    .rd_req_i(rd_req), .rd_rsp_o(rd_rsp), .ch_led_o(ch_led), .tick_o(tick));
  adr_reader host (.clk_i(sys_clk_i), .req_o(rd_req), .rsp_i(rd_rsp));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // enabled edges since reset; the tick is this over 100
  always @(posedge sys_clk_i) begin
    if (srst_i) cycles <= 0;
    else if (clk_en_i) cycles <= cycles + 1;
  end
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    fail_count++;
    results();
  end

  // ---------------------------------------------
  // model and checks
  // ---------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] model(input int ofs);
    logic [7:0] c0;
    logic [7:0] c1;
    c0 = {ch_fault[0].over, ch_fault[0].under, 5'h00, ch_fault[0].cfg_err};
    c1 = {ch_fault[1].over, ch_fault[1].under, 5'h00, ch_fault[1].cfg_err};
    case (ofs)
      0: return {mod_fault.param_err, 2'h0, mod_fault.aux_missing, |{c0, c1},
                 mod_fault.ext_err, mod_fault.int_err, mod_fault.mod_fail};
      1: return 8'h15;
      3: return {3'h0, mod_fault.comm_err, mod_fault.buf_overflow, 3'h0};
      4: return 8'h71;
      5: return 8'h08;
      6: return 8'h02;
      7: return {6'h00, |c1, |c0};
      8: return c0;
      9: return c1;
      16, 17, 18, 19: return 8'(stamp >> (8 * (ofs - 16)));
      default: return 8'h00;
    endcase
  endfunction
  task automatic rd(input adr_path_e p, input int sel, input int sb, input int ofs,
                    input logic hit, input int mofs, input string what);
    adr_rd_rsp_s r;
    host.read(p, 16'(sel), 8'(sb), 5'(ofs), r);
    check({what, "_valid"}, 32'(r.valid), 32'h1);
    check({what, "_hit"}, 32'(r.hit), 32'(hit));
    check(what, 32'(r.data), hit ? 32'(model(mofs)) : 32'h0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    srst_i = 1'b1;
    clk_en_i = 1'b1;
    mod_fault = '0;
    ch_fault = '0;
    repeat (8) @(negedge sys_clk_i);
    srst_i = 1'b0;
    check("led_rst", 32'(ch_led), 32'h0);
    for (int i = 0; i < 20; i++) begin
      rd(ADR_PATH_DS, 'h01, 0, i, 1'b1, i, "ds_full");
      rd(ADR_PATH_IX, 'h2f01, 0, i, 1'b1, i, "ix_full");
    end
    for (int i = 0; i < 6; i++) begin
      rd(ADR_PATH_DS, 'h00, 0, i, i < 4, i, "ds_short");
      rd(ADR_PATH_IX, 'h2f00, 0, i, i < 4, i, "ix_short");
    end
    rd(ADR_PATH_DS, 'h02, 0, 0, 1'b0, 0, "ds_unmapped");
    rd(ADR_PATH_IX, 'h2f02, 0, 0, 1'b0, 0, "ix_unmapped");
    $display("test reset_record done");
    for (int n = 0; n < 6; n++) begin
      mod_fault = '0;
      ch_fault = '0;
      // one quiet edge so that the next fault set is a fresh event
      @(negedge sys_clk_i);
      repeat (200) if (cycles % 100 != 50) @(negedge sys_clk_i);
      check("sync", 32'(cycles % 100), 32'd50);
      mod_fault = 7'($random(seed));
      ch_fault = 6'($random(seed));
      if (mod_fault == '0 && ch_fault == '0) mod_fault.mod_fail = 1'b1;
      stamp = cycles / 100;
      repeat (3) @(negedge sys_clk_i);
      check("led", 32'(ch_led), {30'h0, |ch_fault[1], |ch_fault[0]});
      check("tick", tick, 32'(cycles / 100));
      for (int s = 2; s < 19; s++)
        rd(ADR_PATH_SX, 'h5005, s, 0, s != 18, s - 2, "sx_field");
      for (int o = 0; o < 4; o++)
        rd(ADR_PATH_SX, 'h5005, 'h13, o, 1'b1, 16 + o, "sx_stamp");
      rd(ADR_PATH_SX, 'h5004, 2, 0, 1'b0, 0, "sx_unmapped");
    end
    $display("test fault_record done");
    // frozen enable must hold tick and indicators
    held = tick;
    clk_en_i = 1'b0;
    ch_fault = ~ch_fault;
    repeat (37) @(negedge sys_clk_i);
    check("frozen_tick", tick, held);
    check("frozen_led", 32'(ch_led), {30'h0, |(~ch_fault[1]), |(~ch_fault[0])});
    clk_en_i = 1'b1;
    $display("test freeze done");
    // reset in mid-run with faults still standing
    srst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    srst_i = 1'b0;
    stamp = 0;
    check("rst_led", 32'(ch_led), 32'h0);
    check("rst_tick", tick, 32'h0);
    rd(ADR_PATH_DS, 'h01, 0, 0, 1'b1, 0, "rst_summary");
    rd(ADR_PATH_DS, 'h01, 0, 16, 1'b1, 16, "rst_stamp");
    $display("test mid_reset done");
    results();
  end
endmodule
